// ### common/pscr_cfg.svh
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH

`define PSCR_OFS_IRQ      8'h00
`define PSCR_OFS_EVT_CD   8'h04
`define PSCR_OFS_EVT_FLT  8'h06
`define PSCR_OFS_EVT_STI  8'h08
`define PSCR_OFS_SUP      8'h0a
`define PSCR_OFS_PWR_ST   8'h10
`define PSCR_OFS_DC_EN    8'h14
`define PSCR_OFS_PWR_CMD  8'h19
`define PSCR_OFS_RST_CMD  8'h1a
`define PSCR_OFS_IDENT    8'h1b
`define PSCR_OFS_POL0     8'h1e
`define PSCR_OFS_KEEP0    8'h26
`define PSCR_OFS_KEEP1    8'h2c
`define PSCR_OFS_KEEP2    8'h2e
`define PSCR_OFS_KEEP3    8'h41

`define PSCR_B_CLR_ALL    7
`define PSCR_B_RELEASE    6
`define PSCR_B_SOFT_RST   4

`define PSCR_IRQ_B_CD     2
`define PSCR_IRQ_B_FLT    3
`define PSCR_IRQ_B_STI    4
`define PSCR_IRQ_B_SUP    7

`define PSCR_POL_RST      8'hff
// Identification reset value is arbitrary.
`define PSCR_IDENT_RST    8'h2a

`define PSCR_CLR_MS       5
`define PSCR_MCLK_KHZ     125000
`define PSCR_CLR_CYC      (`PSCR_CLR_MS * `PSCR_MCLK_KHZ)

`endif

// ### common/pscr_pkg.sv
`default_nettype none

package pscr_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pscr_req_t;

  typedef struct packed {
    logic [3:0] class_change_evt;
    logic [3:0] detect_change_evt;
    logic [3:0] disconnect_fault;
    logic [3:0] power_cut_fault;
    logic [3:0] start_fault;
    logic [3:0] current_limit_fault;
    logic       thermal_shutdown;
    logic       logic_supply_warn;
  } pscr_evt_t;

  typedef struct packed {
    logic       logic_supply_uv;
    logic       power_supply_uv;
    logic [3:0] power_good;
  } pscr_lvl_t;

  typedef struct packed {
    logic [7:0] irq;
    logic       hold;
    logic       act;
  } pscr_irq_st_t;

  typedef struct packed {
    logic [7:0]      cd_evt;
    logic [7:0]      flt_evt;
    logic [7:0]      sti_evt;
    logic            thermal_shutdown;
    logic            vd_warn;
    logic [3:0]      pwr_en;
    logic [7:0]      dc_en;
    logic [3:0][7:0] pol;
    logic [7:0]      ident;
    logic [3:0][7:0] keep;
    logic [3:0]      cool;
    logic            soft_rst;
    logic [7:0]      rdata;
  } pscr_quad_st_t;

endpackage : pscr_pkg

`default_nettype wire

// ### verilog/pscr_clr_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscr_cfg.svh"

module pscr_clr_timer #(
  parameter int unsigned CYC = `PSCR_CLR_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  import pscr_pkg::*;

  localparam int unsigned W = $clog2(CYC + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } pscr_tmr_st_t;

  pscr_tmr_st_t st;
  pscr_tmr_st_t nxt;

  // The clear window restarts if the channel is shut down again.
  always_comb begin
    nxt = st;
    if (start) begin
      nxt.cnt = W'(CYC);
    end else if (st.cnt != '0) begin
      nxt.cnt = st.cnt - W'(1);
    end
    nxt.busy = (nxt.cnt != '0);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign busy = st.busy;

  property p_tmr_start;
    @(posedge mclk) disable iff (!rst_n)
      start |=> busy && st.cnt == W'(CYC);
  endproperty
  a_tmr_start: assert property (p_tmr_start)
    else $error("clear window did not open at full length");

  property p_tmr_count;
    @(posedge mclk) disable iff (!rst_n)
      (!start && st.cnt != '0) |=> st.cnt == $past(st.cnt) - W'(1);
  endproperty
  a_tmr_count: assert property (p_tmr_count)
    else $error("clear window count did not step down");

endmodule : pscr_clr_timer

`default_nettype wire

// ### verilog/pscr_irq.sv
`timescale 1ns/1ps
`default_nettype none

module pscr_irq (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] set_vec,
  input  wire logic       clr_all,
  input  wire logic       release_int,
  output logic      [7:0] irq_reg,
  output logic            int_n
);
  import pscr_pkg::*;

  pscr_irq_st_t st;
  pscr_irq_st_t nxt;

  // A new event in the clearing cycle survives the clear.
  always_comb begin
    nxt     = st;
    nxt.irq = (clr_all ? 8'h00 : st.irq) | set_vec;
    nxt.hold = !clr_all && (release_int || st.hold) && (nxt.irq != 8'h00);
    nxt.act  = (nxt.irq != 8'h00) && !nxt.hold;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign irq_reg = st.irq;
  assign int_n   = !st.act;

  property p_irq_release;
    @(posedge mclk) disable iff (!rst_n)
      (release_int && !clr_all) |=> int_n && irq_reg == ($past(irq_reg) | $past(set_vec));
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("release changed the interrupt register or left the pin low");

  property p_irq_hold;
    @(posedge mclk) disable iff (!rst_n)
      (int_n && irq_reg != 8'h00 && !clr_all) |=> int_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("pin asserted while released interrupts were pending");

  property p_irq_clear;
    @(posedge mclk) disable iff (!rst_n)
      (clr_all && set_vec == 8'h00) |=> irq_reg == 8'h00 && int_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("clear all left interrupt bits or the pin set");

endmodule : pscr_irq

`default_nettype wire

// ### verilog/pscr_quad_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscr_cfg.svh"

module pscr_quad_cmd #(
  parameter int unsigned CLR_CYCLES = `PSCR_CLR_CYC,
  parameter logic [7:0]  IDENT_RST  = `PSCR_IDENT_RST
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire pscr_pkg::pscr_req_t req,
  output logic               [7:0] rdata,
  input  wire pscr_pkg::pscr_evt_t evt,
  input  wire pscr_pkg::pscr_lvl_t lvl,
  output logic               [3:0] chan_power_en,
  output logic               [3:0] chan_clear_busy,
  output logic               [3:0] chan_cool_cancel,
  output logic                     soft_reset_pulse,
  output logic                     int_n
);
  import pscr_pkg::*;

  function automatic logic hit(input pscr_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : hit

  function automatic logic [7:0] pol_ofs(input int i);
    return `PSCR_OFS_POL0 + 8'(i);
  endfunction : pol_ofs

  function automatic logic [7:0] keep_ofs(input int i);
    logic [7:0] a;
    a = `PSCR_OFS_KEEP0;
    case (i)
      1: a = `PSCR_OFS_KEEP1;
      2: a = `PSCR_OFS_KEEP2;
      3: a = `PSCR_OFS_KEEP3;
      default: a = `PSCR_OFS_KEEP0;
    endcase
    return a;
  endfunction : keep_ofs

  pscr_quad_st_t st;
  pscr_quad_st_t nxt;

  logic       wr_pwr;
  logic       wr_rst;
  logic       clr_all;
  logic       release_int;
  logic       global_soft_reset;
  logic [3:0] off;
  logic [3:0] on;
  logic [3:0] rsp;
  logic [3:0] kill;
  logic [7:0] kill2;
  logic [7:0] cd_set;
  logic [7:0] flt_set;
  logic [7:0] sti_set;
  logic [7:0] irq_set;
  logic [7:0] irq_q;
  logic [7:0] rd_val;

  // Command decode for the two push-button registers.
  always_comb begin
    wr_pwr      = hit(req, `PSCR_OFS_PWR_CMD);
    wr_rst      = hit(req, `PSCR_OFS_RST_CMD);
    off         = wr_pwr ? req.wdata[7:4] : 4'h0;
    on          = wr_pwr ? (req.wdata[3:0] & ~req.wdata[7:4]) : 4'h0;
    rsp         = wr_rst ? req.wdata[3:0] : 4'h0;
    global_soft_reset = wr_rst && req.wdata[`PSCR_B_SOFT_RST];
    clr_all     = wr_rst && req.wdata[`PSCR_B_CLR_ALL];
    release_int = wr_rst && req.wdata[`PSCR_B_RELEASE];
    kill        = off | rsp | {4{global_soft_reset}};
    kill2       = {kill, kill};
  end

  // Event sources, grouped as the event registers hold them.
  always_comb begin
    cd_set  = {evt.class_change_evt, evt.detect_change_evt};
    flt_set = {evt.disconnect_fault, evt.power_cut_fault};
    sti_set = {evt.start_fault, evt.current_limit_fault};
    irq_set = 8'h00;
    irq_set[`PSCR_IRQ_B_CD]  = (cd_set != 8'h00);
    irq_set[`PSCR_IRQ_B_FLT] = (flt_set != 8'h00);
    irq_set[`PSCR_IRQ_B_STI] = (sti_set != 8'h00);
    irq_set[`PSCR_IRQ_B_SUP] = evt.thermal_shutdown || evt.logic_supply_warn;
  end

  // Next state. An event arriving in a clearing cycle is kept.
  always_comb begin
    nxt = st;

    nxt.cd_evt  = ((clr_all ? 8'h00 : st.cd_evt) & ~kill2) | cd_set;
    nxt.flt_evt = ((clr_all ? 8'h00 : st.flt_evt) & ~kill2) | flt_set;
    nxt.sti_evt = ((clr_all ? 8'h00 : st.sti_evt) & ~kill2) | sti_set;

    // Supply warnings survive a soft reset; only clear-all drops them.
    nxt.thermal_shutdown = (clr_all ? 1'b0 : st.thermal_shutdown) | evt.thermal_shutdown;
    nxt.vd_warn = (clr_all ? 1'b0 : st.vd_warn) | evt.logic_supply_warn;

    nxt.pwr_en = (st.pwr_en & ~kill) | on;

    if (hit(req, `PSCR_OFS_DC_EN)) begin
      nxt.dc_en = req.wdata;
    end
    nxt.dc_en = nxt.dc_en & ~kill2;

    for (int i = 0; i < 4; i++) begin
      if (hit(req, pol_ofs(i))) begin
        nxt.pol[i] = req.wdata;
      end
      if (kill[i]) begin
        nxt.pol[i] = `PSCR_POL_RST;
      end
      if (hit(req, keep_ofs(i))) begin
        nxt.keep[i] = req.wdata;
      end
    end

    if (hit(req, `PSCR_OFS_IDENT)) begin
      nxt.ident = req.wdata;
    end
    if (global_soft_reset) begin
      nxt.ident = IDENT_RST;
    end

    nxt.cool     = rsp;
    nxt.soft_rst = global_soft_reset;
    nxt.rdata    = req.rd ? rd_val : st.rdata;
  end

  // Read data. Push-button and unmapped offsets read zero.
  always_comb begin
    rd_val = 8'h00;
    case (req.addr)
      `PSCR_OFS_IRQ: begin
        rd_val = irq_q;
      end
      `PSCR_OFS_EVT_CD: begin
        rd_val = st.cd_evt;
      end
      `PSCR_OFS_EVT_FLT: begin
        rd_val = st.flt_evt;
      end
      `PSCR_OFS_EVT_STI: begin
        rd_val = st.sti_evt;
      end
      `PSCR_OFS_SUP: begin
        rd_val = {st.thermal_shutdown, lvl.logic_supply_uv, st.vd_warn,
                  lvl.power_supply_uv, 4'h0};
      end
      `PSCR_OFS_PWR_ST: begin
        rd_val = {lvl.power_good & st.pwr_en, st.pwr_en};
      end
      `PSCR_OFS_DC_EN: begin
        rd_val = st.dc_en;
      end
      `PSCR_OFS_IDENT: begin
        rd_val = st.ident;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (req.addr == pol_ofs(i)) begin
        rd_val = st.pol[i];
      end
      if (req.addr == keep_ofs(i)) begin
        rd_val = st.keep[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st       <= '0;
      st.pol   <= {4{`PSCR_POL_RST}};
      st.ident <= IDENT_RST;
    end else begin
      st <= nxt;
    end
  end

  pscr_irq u_irq (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .set_vec     (irq_set),
    .clr_all     (clr_all),
    .release_int (release_int),
    .irq_reg     (irq_q),
    .int_n       (int_n)
  );

  // Downstream measurement and status logic clears during this window.
  for (genvar g = 0; g < 4; g++) begin : g_clr
    pscr_clr_timer #(
      .CYC (CLR_CYCLES)
    ) u_tmr (
      .mclk  (mclk),
      .rst_n (rst_n),
      .start (kill[g]),
      .busy  (chan_clear_busy[g])
    );

    property p_pol_ff;
      @(posedge mclk) disable iff (!rst_n)
        kill[g] |=> st.pol[g] == `PSCR_POL_RST;
    endproperty
    a_pol_ff: assert property (p_pol_ff)
      else $error("policing threshold not restored on shutdown");
  end

  assign rdata            = st.rdata;
  assign chan_power_en    = st.pwr_en;
  assign chan_cool_cancel = st.cool;
  assign soft_reset_pulse = st.soft_rst;

  property p_off_wins;
    @(posedge mclk) disable iff (!rst_n)
      wr_pwr |=> (chan_power_en & $past(req.wdata[7:4])) == 4'h0;
  endproperty
  a_off_wins: assert property (p_off_wins)
    else $error("power off left a channel enabled");

  property p_others_kept;
    @(posedge mclk) disable iff (!rst_n)
      wr_pwr |=> chan_power_en ==
        (($past(chan_power_en) | $past(req.wdata[3:0])) & ~$past(req.wdata[7:4]));
  endproperty
  a_others_kept: assert property (p_others_kept)
    else $error("power command disturbed an unselected channel");

  property p_chan_evt;
    @(posedge mclk) disable iff (!rst_n)
      (rsp != 4'h0 && cd_set == 8'h00) |=> (st.cd_evt & {2{$past(rsp)}}) == 8'h00;
  endproperty
  a_chan_evt: assert property (p_chan_evt)
    else $error("channel reset left change events set");

  property p_clr_all;
    @(posedge mclk) disable iff (!rst_n)
      (clr_all && cd_set == 8'h00 && flt_set == 8'h00 && sti_set == 8'h00)
        |=> st.cd_evt == 8'h00 && st.flt_evt == 8'h00 && st.sti_evt == 8'h00;
  endproperty
  a_clr_all: assert property (p_clr_all)
    else $error("clear all left event bits set");

  property p_cool;
    @(posedge mclk) disable iff (!rst_n)
      wr_rst |=> chan_cool_cancel == $past(req.wdata[3:0])
        ##1 ($past(wr_rst) || chan_cool_cancel == 4'h0);
  endproperty
  a_cool: assert property (p_cool)
    else $error("cool-down cancel not a single pulse per reset bit");

  property p_busy;
    @(posedge mclk) disable iff (!rst_n)
      (rsp != 4'h0) |-> ##1 (chan_clear_busy & $past(rsp)) == $past(rsp);
  endproperty
  a_busy: assert property (p_busy)
    else $error("clear window missing after channel reset");

  property p_soft_rst;
    @(posedge mclk) disable iff (!rst_n)
      global_soft_reset |=> st.keep == $past(st.keep) && st.ident == IDENT_RST
        && st.dc_en == 8'h00 && soft_reset_pulse;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset lost a preserved register or kept state");

  property p_rd_zero;
    @(posedge mclk) disable iff (!rst_n)
      (req.rd && req.addr == `PSCR_OFS_RST_CMD) |=> rdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("reset command register read nonzero");

endmodule : pscr_quad_cmd

`default_nettype wire

// ### tb/pscr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pscr_host_model #(
  parameter int WAIT_CYC = 20
) (
  input  wire logic               mclk,
  output var  pscr_pkg::pscr_req_t req
);
  import pscr_pkg::*;
  int cyc    = 0;
  int rst_at = -1000;

  initial req = '0;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    req = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req = '0;
  endtask : xfer

  // Power-on and discovery writes wait out the settle time after a channel reset.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if ((a == 8'h19 && d[3:0] != 4'h0) || a == 8'h14) begin
      while (cyc - rst_at < WAIT_CYC) begin
        @(posedge mclk);
      end
    end
    xfer(1'b1, 1'b0, a, d);
    if (a == 8'h1a && d[3:0] != 4'h0) begin
      rst_at = cyc;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : idle
endmodule : pscr_host_model

`default_nettype wire

// ### tb/pscr_quad_cmd_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pscr_quad_cmd_tb;
  import pscr_pkg::*;
  localparam int unsigned CLR = 16;
  // Identification reset value is arbitrary.
  localparam logic [7:0] IDV = 8'h5c;
  localparam logic [7:0] OFS [5] = '{8'h04, 8'h06, 8'h08, 8'h10, 8'h14};
  logic       mclk  = 1'b0;
  logic       rst_n = 1'b0;
  pscr_req_t  req;
  pscr_evt_t  evt   = '0;
  pscr_lvl_t  lvl   = '{1'b1, 1'b0, 4'hf};
  logic [7:0] rdata;
  logic [3:0] pwr_en;
  logic [3:0] busy;
  logic [3:0] cool;
  logic       srst;
  logic       int_n;
  logic [7:0] exp_q [$];
  logic       rd_d  = 1'b0;
  int         cyc   = 0;
  int         t0;
  int         miscompares = 0;
  int         check_count = 0;
  int         seed  = 32'h3a01;
  logic [7:0] k_v;
  logic [7:0] p_v;

  always #4 mclk = ~mclk;

  pscr_quad_cmd #(.CLR_CYCLES(CLR), .IDENT_RST(IDV)) u_pscr_quad_cmd (
    .mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .evt(evt), .lvl(lvl),
    .chan_power_en(pwr_en), .chan_clear_busy(busy), .chan_cool_cancel(cool),
    .soft_reset_pulse(srst), .int_n(int_n));

  pscr_host_model #(.WAIT_CYC(20)) u_pscr_host_model (.mclk(mclk), .req(req));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_pscr_host_model.wr(a, d);
  endtask : wr

  task automatic idle(input int n);
    u_pscr_host_model.idle(n);
  endtask : idle

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_pscr_host_model.rd(a);
  endtask : rd_chk

  task automatic pulse(input pscr_evt_t e);
    evt = e;
    @(posedge mclk);
    #1;
    evt = '0;
  endtask : pulse

  // Read data lands on the edge that takes the read strobe and is checked one edge later.
  always @(posedge mclk) begin
    cyc  <= cyc + 1;
    rd_d <= req.rd;
    if (rd_d) begin
      check(rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    k_v = 8'($random(seed));
    p_v = 8'($random(seed));
    rd_chk(8'h1b, IDV);
    rd_chk(8'h1e, 8'hff);
    rd_chk(8'h21, 8'hff);
    rd_chk(8'h1a, 8'h00);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h7f, 8'h00);
    check({7'h0, int_n}, 8'h01);
    wr(8'h1b, p_v ^ 8'h5a);
    wr(8'h26, k_v);
    wr(8'h2c, ~k_v);
    wr(8'h2e, p_v);
    wr(8'h41, k_v ^ p_v);
    wr(8'h1f, p_v);
    rd_chk(8'h1b, p_v ^ 8'h5a);
    $display("done reset values");
    wr(8'h19, 8'h0f);
    wr(8'h14, 8'hff);
    check({4'h0, pwr_en}, 8'h0f);
    // Every per-channel event of all four channels at once.
    pulse(pscr_evt_t'(26'h3fffffc));
    idle(1);
    check({7'h0, int_n}, 8'h00);
    rd_chk(8'h00, 8'h1c);
    wr(8'h19, 8'h11);
    t0 = cyc;
    check({4'h0, pwr_en}, 8'h0e);
    check({4'h0, busy}, 8'h01);
    check({4'h0, cool}, 8'h00);
    for (int i = 0; i < 5; i++) rd_chk(OFS[i], 8'hee);
    rd_chk(8'h1e, 8'hff);
    rd_chk(8'h1f, p_v);
    while (busy[0] === 1'b1 && cyc - t0 < CLR + 8) idle(1);
    check(8'(cyc - t0), 8'(CLR));
    if (busy[0] !== 1'b0) begin
      miscompares++;
      conclude();
    end
    $display("done power off");
    wr(8'h20, 8'h33);
    wr(8'h1a, 8'h04);
    check({4'h0, cool}, 8'h04);
    check({4'h0, pwr_en}, 8'h0a);
    check({4'h0, busy}, 8'h04);
    idle(1);
    check({4'h0, cool}, 8'h00);
    for (int i = 0; i < 5; i++) rd_chk(OFS[i], 8'haa);
    rd_chk(8'h20, 8'hff);
    wr(8'h1a, 8'h20);
    check({4'h0, pwr_en}, 8'h0a);
    rd_chk(8'h1a, 8'h00);
    wr(8'h19, 8'h04);
    check({4'h0, pwr_en}, 8'h0e);
    $display("done channel reset");
    wr(8'h1a, 8'h40);
    check({7'h0, int_n}, 8'h01);
    rd_chk(8'h04, 8'haa);
    rd_chk(8'h00, 8'h1c);
    pulse(pscr_evt_t'(26'h40));
    idle(1);
    check({7'h0, int_n}, 8'h01);
    rd_chk(8'h08, 8'hba);
    wr(8'h1a, 8'h80);
    check({7'h0, int_n}, 8'h01);
    for (int i = 0; i < 3; i++) rd_chk(OFS[i], 8'h00);
    rd_chk(8'h00, 8'h00);
    pulse(pscr_evt_t'(26'h200000));
    idle(1);
    check({7'h0, int_n}, 8'h00);
    $display("done interrupt release");
    lvl.power_supply_uv = 1'b1;
    pulse(pscr_evt_t'(26'h3));
    rd_chk(8'h0a, 8'hf0);
    wr(8'h1a, 8'h10);
    check({7'h0, srst}, 8'h01);
    check({4'h0, pwr_en}, 8'h00);
    idle(1);
    check({7'h0, srst}, 8'h00);
    rd_chk(8'h1b, IDV);
    rd_chk(8'h1f, 8'hff);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h26, k_v);
    rd_chk(8'h2c, ~k_v);
    rd_chk(8'h2e, p_v);
    rd_chk(8'h41, k_v ^ p_v);
    rd_chk(8'h00, 8'h84);
    rd_chk(8'h0a, 8'hf0);
    lvl.logic_supply_uv = 1'b0;
    rd_chk(8'h0a, 8'hb0);
    idle(2);
    $display("done soft reset");
    conclude();
  end
endmodule : pscr_quad_cmd_tb

`default_nettype wire
